// ### core/i2crc_pkg.sv
// Package with register map, field positions, rate tables and states of the bus controller.
package i2crc_pkg;

    // Register byte offsets.
    localparam logic [7:0] I2CRC_OFS_RATE = 8'h00;
    localparam logic [7:0] I2CRC_OFS_CTRL = 8'h04;
    localparam logic [7:0] I2CRC_OFS_STAT = 8'h08;
    localparam logic [7:0] I2CRC_OFS_MASK = 8'h0c;
    localparam logic [7:0] I2CRC_OFS_DATA = 8'h10;
    localparam logic [7:0] I2CRC_OFS_INFO = 8'h14;

    // Control field positions.
    localparam int I2CRC_CTRL_EN   = 7;
    localparam int I2CRC_CTRL_IE   = 6;
    localparam int I2CRC_CTRL_MST  = 5;
    localparam int I2CRC_CTRL_TX   = 4;
    localparam int I2CRC_CTRL_ACK  = 3;
    localparam int I2CRC_CTRL_REPEATED_START_BIT = 2;

    // Rate divider fields, status and info bit positions.
    localparam int I2CRC_RATE_RATE_MULTIPLIER = 6;
    localparam int I2CRC_STAT_DONE = 0;
    localparam int I2CRC_STAT_ARBL = 1;
    localparam int I2CRC_INFO_BUSY = 0;
    localparam int I2CRC_INFO_MAST = 1;
    localparam int I2CRC_INFO_RXAK = 2;

    // Reset values.
    localparam logic [7:0] I2CRC_RATE_RST = 8'h00;
    localparam logic [7:0] I2CRC_CTRL_RST = 8'h00;
    localparam logic [1:0] I2CRC_STAT_RST = 2'h0;
    localparam logic [1:0] I2CRC_MASK_RST = 2'h0;

    // Clock divider and data hold count for rate index 0x00 to 0x1f.
    localparam logic [11:0] I2CRC_DIV_LO [0:31] = '{
        12'h014, 12'h016, 12'h018, 12'h01a, 12'h01c, 12'h01e, 12'h022, 12'h028,
        12'h01c, 12'h020, 12'h024, 12'h028, 12'h02c, 12'h030, 12'h038, 12'h044,
        12'h030, 12'h038, 12'h040, 12'h048, 12'h050, 12'h058, 12'h068, 12'h080,
        12'h050, 12'h060, 12'h070, 12'h080, 12'h090, 12'h0a0, 12'h0c0, 12'h0f0};
    localparam logic [9:0] I2CRC_HOLD_LO [0:31] = '{
        10'h007, 10'h007, 10'h008, 10'h008, 10'h009, 10'h009, 10'h00a, 10'h00a,
        10'h007, 10'h007, 10'h009, 10'h009, 10'h00b, 10'h00b, 10'h00d, 10'h00d,
        10'h009, 10'h009, 10'h00d, 10'h00d, 10'h011, 10'h011, 10'h015, 10'h015,
        10'h009, 10'h009, 10'h011, 10'h011, 10'h019, 10'h019, 10'h021, 10'h021};

    // Clock divider and data hold count for rate index 0x20 to 0x3f.
    localparam logic [11:0] I2CRC_DIV_HI [0:31] = '{
        12'h0a0, 12'h0c0, 12'h0e0, 12'h100, 12'h120, 12'h140, 12'h180, 12'h1e0,
        12'h140, 12'h180, 12'h1c0, 12'h200, 12'h240, 12'h280, 12'h300, 12'h3c0,
        12'h280, 12'h300, 12'h380, 12'h400, 12'h480, 12'h500, 12'h600, 12'h780,
        12'h500, 12'h600, 12'h700, 12'h800, 12'h900, 12'ha00, 12'hc00, 12'hf00};
    localparam logic [9:0] I2CRC_HOLD_HI [0:31] = '{
        10'h011, 10'h011, 10'h021, 10'h021, 10'h031, 10'h031, 10'h041, 10'h041,
        10'h021, 10'h021, 10'h041, 10'h041, 10'h061, 10'h061, 10'h081, 10'h081,
        10'h041, 10'h041, 10'h081, 10'h081, 10'h0c1, 10'h0c1, 10'h101, 10'h101,
        10'h081, 10'h081, 10'h101, 10'h101, 10'h181, 10'h181, 10'h201, 10'h201};

    // Bus engine states.
    typedef enum logic [3:0] {
        I2CRC_IDLE, I2CRC_START, I2CRC_WAIT, I2CRC_LOW, I2CRC_HIGH,
        I2CRC_STOP_A, I2CRC_STOP_B, I2CRC_STOP_C, I2CRC_RS_A, I2CRC_RS_B
    } i2crc_state_e;

endpackage

// ### core/i2crc_core.sv
// Two-wire bus controller with rate lookup, control register and AHB-Lite register slave.
//
// Function
// [R01] Rate index 0x00-0x1f picks divider and hold count from first table.
// [R02] Rate index 0x20-0x3f picks divider and hold count from second table.
// [R03] Controller runs only while enable bit 7 is one.
// [R04] Interrupt request raised only while interrupt enable bit 6 is one.
// [R05] Master select rising makes a START and enters master operation.
// [R06] Master select falling makes a STOP and returns to slave operation.
// [R07] Direction bit 4: zero receives, one transmits.
// [R08] Software keeps direction matching the transfer, transmit for address bytes.
// [R09] Software sets direction per captured slave read/write flag when addressed.
// [R10] Receiver acknowledge: drive data low when bit 3 is zero, else no acknowledge.
// [R11] Writing one to bit 2 makes a repeated START while current master.
// [R12] Repeated-start bit always reads zero.
// [R13] Repeated START at improper time counts as lost arbitration.
// [R14] Bit rate is bus clock over multiplier times selected divider.
// [R15] Multiplier field: 00 gives 1, 01 gives 2, 10 gives 4, 11 reserved.
// [R16] Data changes hold count cycles after the falling serial clock edge.
// [R17] Disabled controller releases both lines and ignores the bus.
`timescale 1ns/1ps
`default_nettype none

module i2crc_core (
    input  wire logic        mclk_i,      // Bus clock, 25 MHz.
    input  wire logic        reset_i,     // Synchronous reset, active high.
    input  wire logic        hsel_i,      // AHB slave select.
    input  wire logic [31:0] haddr_i,     // AHB address.
    input  wire logic [1:0]  htrans_i,    // AHB transfer type.
    input  wire logic        hwrite_i,    // AHB write strobe.
    input  wire logic [2:0]  hsize_i,     // AHB size, word only.
    input  wire logic [31:0] hwdata_i,    // AHB write data.
    input  wire logic        hready_i,    // AHB bus ready.
    output logic             hreadyout_o, // AHB slave ready.
    output logic             hresp_o,     // AHB response, always OKAY.
    output logic [31:0]      hrdata_o,    // AHB read data.
    input  wire logic        scl_i,       // Serial clock line level.
    output logic             scl_o,       // Serial clock drive value.
    output logic             scl_oe_o,    // Serial clock pulled low while high.
    input  wire logic        sda_i,       // Serial data line level.
    output logic             sda_o,       // Serial data drive value.
    output logic             sda_oe_o,    // Serial data pulled low while high.
    output logic             irq_o        // Level interrupt request.
);
    import i2crc_pkg::*;

    logic [7:0]   rate_reg, rate_next;
    logic [7:0]   ctrl_reg, ctrl_next;
    logic [1:0]   stat_reg, stat_next;
    logic [1:0]   mask_reg, mask_next;
    logic [7:0]   txd_reg, txd_next;
    logic [7:0]   rxd_reg, rxd_next;
    logic [7:0]   shift_reg, shift_next;
    i2crc_state_e state_reg, state_next;
    logic [12:0]  cnt_reg, cnt_next;
    logic [3:0]   bit_reg, bit_next;
    logic         dir_reg, dir_next;
    logic         rxak_reg, rxak_next;
    logic         scl_drv_reg, scl_drv_next;
    logic         sda_drv_reg, sda_drv_next;
    logic         go_reg, go_next;
    logic         ap_wr_reg, ap_wr_next;
    logic [7:0]   ap_addr_reg, ap_addr_next;
    logic [31:0]  hrdata_reg, hrdata_next;

    logic [11:0]  div_sel;
    logic [9:0]   hold_sel;
    logic [13:0]  prod;
    logic [12:0]  half_m1;
    logic         phase_end;
    logic         hold_hit;
    logic         sda_bit;
    logic         rs_req;
    logic         lost;
    logic [1:0]   stat_set;
    logic [1:0]   stat_clr;
    logic         ap_take;
    logic         master;

    // Rate selection from the index; the index msb chooses the table.
    // [R01] [R02] First table below 0x20, second table from 0x20 up.
    assign div_sel  = rate_reg[5] ? I2CRC_DIV_HI[rate_reg[4:0]] : I2CRC_DIV_LO[rate_reg[4:0]];
    assign hold_sel = rate_reg[5] ? I2CRC_HOLD_HI[rate_reg[4:0]] : I2CRC_HOLD_LO[rate_reg[4:0]];

    // A bit period is mul times divider cycles, split in two halves.
    always_comb
    begin
        // [R15] Multiplier decode, reserved code runs as factor one.
        unique case (rate_reg[I2CRC_RATE_RATE_MULTIPLIER +: 2])
            2'h1:    prod = {1'b0, div_sel, 1'b0};
            2'h2:    prod = {div_sel, 2'h0};
            default: prod = {2'h0, div_sel};
        endcase
        // [R14] Half period counted in bus clocks.
        half_m1 = prod[13:1] - 13'h0001;
    end

    assign phase_end = (cnt_reg == half_m1);
    // [R16] Hold point; the change lands hold count cycles after the clock fell.
    assign hold_hit  = (cnt_reg == ({3'h0, hold_sel} - 13'h0001));
    assign master    = (state_reg != I2CRC_IDLE);
    assign ap_take   = hsel_i && hready_i && htrans_i[1];

    // Value for the current bit: data, or acknowledge slot in the ninth bit.
    // [R10] Receiver sends acknowledge per the acknowledge control bit.
    assign sda_bit = (bit_reg != 4'h8) ? (dir_reg ? shift_reg[7] : 1'b1)
                                       : (dir_reg ? 1'b1 : ctrl_reg[I2CRC_CTRL_ACK]);

    // Next state of registers, bus slave and bus engine.
    always_comb
    begin
        rate_next    = rate_reg;
        ctrl_next    = ctrl_reg;
        mask_next    = mask_reg;
        txd_next     = txd_reg;
        rxd_next     = rxd_reg;
        shift_next   = shift_reg;
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        bit_next     = bit_reg;
        dir_next     = dir_reg;
        rxak_next    = rxak_reg;
        scl_drv_next = scl_drv_reg;
        sda_drv_next = sda_drv_reg;
        go_next      = go_reg;
        ap_wr_next   = 1'b0;
        ap_addr_next = ap_addr_reg;
        hrdata_next  = hrdata_reg;
        rs_req       = 1'b0;
        lost         = 1'b0;
        stat_set     = 2'h0;
        stat_clr     = 2'h0;

        // Data phase of a write: the value stands on hwdata now.
        if (ap_wr_reg)
        begin
            case (ap_addr_reg)
                I2CRC_OFS_RATE: rate_next = hwdata_i[7:0];
                I2CRC_OFS_CTRL:
                begin
                    // [R12] Repeated-start bit is never stored.
                    ctrl_next = hwdata_i[7:0] & ~(8'h01 << I2CRC_CTRL_REPEATED_START_BIT);
                    // [R11] Request a repeated start.
                    rs_req    = hwdata_i[I2CRC_CTRL_REPEATED_START_BIT];
                end
                I2CRC_OFS_STAT: stat_clr = hwdata_i[1:0];
                I2CRC_OFS_MASK: mask_next = hwdata_i[1:0];
                I2CRC_OFS_DATA:
                begin
                    txd_next = hwdata_i[7:0];
                    // [R07] A write starts a byte only in transmit.
                    go_next  = master && ctrl_reg[I2CRC_CTRL_TX];
                end
                default: ;
            endcase
        end

        // Address phase: reads are answered from flops in the next cycle.
        if (ap_take)
        begin
            ap_wr_next   = hwrite_i;
            ap_addr_next = haddr_i[7:0];
            hrdata_next  = 32'h0000_0000;
            if (!hwrite_i)
            begin
                case (haddr_i[7:0])
                    I2CRC_OFS_RATE: hrdata_next[7:0] = rate_reg;
                    I2CRC_OFS_CTRL: hrdata_next[7:0] = ctrl_reg;
                    I2CRC_OFS_STAT: hrdata_next[1:0] = stat_reg;
                    I2CRC_OFS_MASK: hrdata_next[1:0] = mask_reg;
                    I2CRC_OFS_DATA:
                    begin
                        hrdata_next[7:0] = rxd_reg;
                        // [R07] A read starts the next byte only in receive.
                        go_next = go_next || (master && !ctrl_reg[I2CRC_CTRL_TX]);
                    end
                    I2CRC_OFS_INFO:
                    begin
                        hrdata_next[I2CRC_INFO_BUSY] = master;
                        hrdata_next[I2CRC_INFO_MAST] = ctrl_reg[I2CRC_CTRL_MST];
                        hrdata_next[I2CRC_INFO_RXAK] = rxak_reg;
                    end
                    default: ;
                endcase
            end
        end

        // Bus engine; drivers pull the line low while set.
        unique case (state_reg)
            I2CRC_IDLE:
            begin
                scl_drv_next = 1'b0;
                sda_drv_next = 1'b0;
                cnt_next     = 13'h0000;
                if (ctrl_reg[I2CRC_CTRL_MST])
                begin
                    // [R05] Data falls while the clock is high.
                    sda_drv_next = 1'b1;
                    state_next   = I2CRC_START;
                end
            end
            I2CRC_START:
            begin
                cnt_next = cnt_reg + 13'h0001;
                if (phase_end)
                begin
                    scl_drv_next = 1'b1;
                    cnt_next     = 13'h0000;
                    state_next   = I2CRC_WAIT;
                end
            end
            I2CRC_WAIT:
            begin
                // Clock held low between bytes; data released after hold.
                cnt_next     = hold_hit ? cnt_reg : cnt_reg + 13'h0001;
                sda_drv_next = hold_hit ? 1'b0 : sda_drv_reg;
                if (!ctrl_reg[I2CRC_CTRL_MST])
                begin
                    // [R06] Leave master operation through a STOP.
                    sda_drv_next = 1'b1;
                    cnt_next     = 13'h0000;
                    state_next   = I2CRC_STOP_A;
                end
                else if (go_reg)
                begin
                    go_next    = 1'b0;
                    bit_next   = 4'h0;
                    cnt_next   = 13'h0000;
                    // [R07] Direction is latched for the whole byte.
                    dir_next   = ctrl_reg[I2CRC_CTRL_TX];
                    shift_next = ctrl_reg[I2CRC_CTRL_TX] ? txd_reg : 8'h00;
                    state_next = I2CRC_LOW;
                end
            end
            I2CRC_LOW:
            begin
                cnt_next = cnt_reg + 13'h0001;
                if (hold_hit)
                begin
                    // [R16] Data line changes at the hold point.
                    sda_drv_next = ~sda_bit;
                end
                if (phase_end)
                begin
                    scl_drv_next = 1'b0;
                    cnt_next     = 13'h0000;
                    state_next   = I2CRC_HIGH;
                end
            end
            I2CRC_HIGH:
            begin
                // A slave stretching the clock pauses the count.
                cnt_next = scl_i ? cnt_reg + 13'h0001 : cnt_reg;
                if (scl_i && phase_end)
                begin
                    cnt_next     = 13'h0000;
                    scl_drv_next = 1'b1;
                    if (dir_reg && (bit_reg != 4'h8) && !sda_drv_reg && !sda_i)
                    begin
                        lost = 1'b1;
                    end
                    else if (bit_reg == 4'h8)
                    begin
                        rxak_next  = dir_reg ? sda_i : rxak_reg;
                        rxd_next   = dir_reg ? rxd_reg : shift_reg;
                        stat_set[I2CRC_STAT_DONE] = 1'b1;
                        state_next = I2CRC_WAIT;
                    end
                    else
                    begin
                        bit_next   = bit_reg + 4'h1;
                        shift_next = {shift_reg[6:0], dir_reg ? 1'b0 : sda_i};
                        state_next = I2CRC_LOW;
                    end
                end
            end
            I2CRC_STOP_A:
            begin
                cnt_next = cnt_reg + 13'h0001;
                if (phase_end)
                begin
                    scl_drv_next = 1'b0;
                    cnt_next     = 13'h0000;
                    state_next   = I2CRC_STOP_B;
                end
            end
            I2CRC_STOP_B:
            begin
                cnt_next = cnt_reg + 13'h0001;
                if (phase_end)
                begin
                    // [R06] Data rises while the clock is high.
                    sda_drv_next = 1'b0;
                    cnt_next     = 13'h0000;
                    state_next   = I2CRC_STOP_C;
                end
            end
            I2CRC_STOP_C:
            begin
                // Bus free time before a new start may follow.
                cnt_next = cnt_reg + 13'h0001;
                if (phase_end)
                begin
                    state_next = I2CRC_IDLE;
                end
            end
            I2CRC_RS_A:
            begin
                sda_drv_next = 1'b0;
                cnt_next     = cnt_reg + 13'h0001;
                if (phase_end)
                begin
                    scl_drv_next = 1'b0;
                    cnt_next     = 13'h0000;
                    state_next   = I2CRC_RS_B;
                end
            end
            I2CRC_RS_B:
            begin
                cnt_next = cnt_reg + 13'h0001;
                if (phase_end)
                begin
                    sda_drv_next = 1'b1;
                    cnt_next     = 13'h0000;
                    state_next   = I2CRC_START;
                end
            end
        endcase

        // [R11] Repeated start only from a held clock as master.
        if (rs_req)
        begin
            if ((state_reg == I2CRC_WAIT) && ctrl_next[I2CRC_CTRL_MST])
            begin
                cnt_next   = 13'h0000;
                go_next    = 1'b0;
                state_next = I2CRC_RS_A;
            end
            else
            begin
                // [R13] Wrong timing counts as lost arbitration.
                lost = 1'b1;
            end
        end

        // Lost arbitration drops mastership without a stop.
        if (lost)
        begin
            stat_set[I2CRC_STAT_ARBL] = 1'b1;
            ctrl_next[I2CRC_CTRL_MST] = 1'b0;
            scl_drv_next = 1'b0;
            sda_drv_next = 1'b0;
            go_next      = 1'b0;
            cnt_next     = 13'h0000;
            state_next   = I2CRC_IDLE;
        end

        // [R03] [R17] Disabled: lines released and bus ignored.
        if (!ctrl_next[I2CRC_CTRL_EN])
        begin
            scl_drv_next = 1'b0;
            sda_drv_next = 1'b0;
            go_next      = 1'b0;
            cnt_next     = 13'h0000;
            state_next   = I2CRC_IDLE;
        end

        // Set wins over a write-one clear in the same cycle.
        stat_next = (stat_reg & ~stat_clr) | stat_set;
    end

    // Register update.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            rate_reg    <= I2CRC_RATE_RST;
            ctrl_reg    <= I2CRC_CTRL_RST;
            stat_reg    <= I2CRC_STAT_RST;
            mask_reg    <= I2CRC_MASK_RST;
            txd_reg     <= 8'h00;
            rxd_reg     <= 8'h00;
            shift_reg   <= 8'h00;
            state_reg   <= I2CRC_IDLE;
            cnt_reg     <= 13'h0000;
            bit_reg     <= 4'h0;
            dir_reg     <= 1'b0;
            rxak_reg    <= 1'b0;
            scl_drv_reg <= 1'b0;
            sda_drv_reg <= 1'b0;
            go_reg      <= 1'b0;
            ap_wr_reg   <= 1'b0;
            ap_addr_reg <= 8'h00;
            hrdata_reg  <= 32'h0000_0000;
        end
        else
        begin
            rate_reg    <= rate_next;
            ctrl_reg    <= ctrl_next;
            stat_reg    <= stat_next;
            mask_reg    <= mask_next;
            txd_reg     <= txd_next;
            rxd_reg     <= rxd_next;
            shift_reg   <= shift_next;
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            bit_reg     <= bit_next;
            dir_reg     <= dir_next;
            rxak_reg    <= rxak_next;
            scl_drv_reg <= scl_drv_next;
            sda_drv_reg <= sda_drv_next;
            go_reg      <= go_next;
            ap_wr_reg   <= ap_wr_next;
            ap_addr_reg <= ap_addr_next;
            hrdata_reg  <= hrdata_next;
        end
    end

    // Zero-wait slave; open-drain pins only ever pull low.
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = hrdata_reg;
    assign scl_o       = 1'b0;
    assign sda_o       = 1'b0;
    assign scl_oe_o    = scl_drv_reg;
    assign sda_oe_o    = sda_drv_reg;
    // [R04] Request gated by enable and interrupt enable.
    assign irq_o = ctrl_reg[I2CRC_CTRL_EN] && ctrl_reg[I2CRC_CTRL_IE] && |(stat_reg & mask_reg);

endmodule // i2crc_core

`default_nettype wire

// ### test/i2crc_sva.sv
// Port checker for the bus controller, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module i2crc_sva
    import i2crc_pkg::*;
(
    input wire logic        mclk_i,   // Clock.
    input wire logic        reset_i,  // Reset.
    input wire logic        hsel_i,   // Select.
    input wire logic [31:0] haddr_i,  // Address.
    input wire logic [1:0]  htrans_i, // Transfer.
    input wire logic        hwrite_i, // Write.
    input wire logic [31:0] hwdata_i, // Write data.
    input wire logic        hready_i, // Ready.
    input wire logic [31:0] hrdata_o, // Read data.
    input wire logic        scl_oe_o, // Clock pull.
    input wire logic        sda_oe_o, // Data pull.
    input wire logic        irq_o     // Interrupt.
);
    logic       w_q;
    logic       r_q;
    logic [7:0] a_q;
    logic [7:0] ctl_q;
    logic [7:0] rate_q;
    // Shadow of written settings; hardware master clears are not seen.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            {w_q, r_q, a_q, ctl_q, rate_q} <= '0;
        end
        else
        begin
            if (hready_i)
            begin
                w_q <= hsel_i && htrans_i[1] && hwrite_i;
                r_q <= hsel_i && htrans_i[1] && !hwrite_i;
                a_q <= haddr_i[7:0];
            end
            if (w_q && a_q == I2CRC_OFS_CTRL) ctl_q <= hwdata_i[7:0];
            if (w_q && a_q == I2CRC_OFS_RATE) rate_q <= hwdata_i[7:0];
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    property p_irq; !(ctl_q[7] && ctl_q[6]) |-> !irq_o; endproperty
    a_irq: assert property (p_irq) else $error("irq without enables");
    property p_rel; !ctl_q[7] [*2] |-> !scl_oe_o && !sda_oe_o; endproperty
    a_rel: assert property (p_rel) else $error("lines held while off");
    property p_rd; r_q && a_q == I2CRC_OFS_CTRL |->
        {hrdata_o[7:6], hrdata_o[4:2]} == {ctl_q[7:6], ctl_q[4:3], 1'b0}; endproperty
    a_rd: assert property (p_rd) else $error("control readback wrong");
    property p_up; r_q |-> hrdata_o[31:8] == 24'h0; endproperty
    a_up: assert property (p_up) else $error("upper read bits set");
    property p_st; $rose(ctl_q[5]) && ctl_q[7] |-> ##[1:20] sda_oe_o; endproperty
    a_st: assert property (p_st) else $error("no start");
    property p_sp; $fell(ctl_q[5]) && ctl_q[7] |-> ##[1:1000] !scl_oe_o && !sda_oe_o; endproperty
    a_sp: assert property (p_sp) else $error("no stop");
    property p_hd; $rose(scl_oe_o) && rate_q == 8'h00 |-> ##1 $stable(sda_oe_o) [*5]; endproperty
    a_hd: assert property (p_hd) else $error("data moved early");
    property p_hf; $fell(scl_oe_o) && rate_q == 8'h00 |-> !scl_oe_o [*8]; endproperty
    a_hf: assert property (p_hf) else $error("clock high too short");
    c_st: cover property ($rose(sda_oe_o));
    c_sp: cover property ($fell(sda_oe_o) && !scl_oe_o);
    c_irq: cover property ($rose(irq_o));
endmodule // i2crc_sva
bind i2crc_core i2crc_sva u_sva (.mclk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hwdata_i, .hready_i, .hrdata_o, .scl_oe_o, .sda_oe_o, .irq_o);
`default_nettype wire

// ### test/i2crc_peer.sv
// Far-side receiver model that acknowledges every byte on the wire.
`timescale 1ns/1ps
`default_nettype none
module i2crc_peer (
    input  wire logic scl_i,    // Clock line level.
    input  wire logic sda_i,    // Data line level.
    input  wire logic ack_en_i, // Answer bytes.
    output logic      sda_oe_o  // Pull data low.
);
    int edges = 0;
    // A START clears the count; each clock fall steps it.
    always @(negedge sda_i) if (scl_i) edges = 0;
    always @(negedge scl_i) edges = edges + 1;
    // Only each ninth clock, low and high phase, is pulled; the pull-up wins elsewhere.
    assign sda_oe_o = ack_en_i && edges > 0 && (edges - 1) % 9 == 8;
endmodule // i2crc_peer
`default_nettype wire

// ### test/i2c_rate_and_control_tb.sv
// Self-checking bench for the bus controller rate and control logic.
`timescale 1ns/1ps
`default_nettype none
module i2c_rate_and_control_tb;
    import i2crc_pkg::*;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        hsel, hwrite, hrdy, irq, scl_oe, sda_oe, peer_oe;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          n;
    // Expected figures per pass: setting, multiplier, divider, hold count.
    logic [7:0]  rate_t [5] = '{8'h00, 8'h5f, 8'h9a, 8'h20, 8'hc0};
    int          mul_t [5] = '{1, 2, 4, 1, 1};
    int          div_t [5] = '{20, 240, 112, 160, 20};
    int          hold_t [5] = '{7, 33, 17, 17, 7};
    wire         scl = !scl_oe;
    wire         sda = !(sda_oe || peer_oe);
    i2crc_core dut_u (.mclk_i, .reset_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hreadyout_o(hrdy), .hresp_o(), .hrdata_o(hrdata), .scl_i(scl), .scl_o(),
        .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .irq_o(irq));
    i2crc_peer peer_u (.scl_i(scl), .sda_i(sda), .ack_en_i(1'b1), .sda_oe_o(peer_oe));
    always #20 mclk_i = !mclk_i;
    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard, well above the expected run.
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_fail++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One word transfer; ready is waited for, never assumed.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge mclk_i); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk_i); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask
    // Counts cycles a line keeps one value.
    task automatic hold_len(ref logic s, input logic v);
        n = 0;
        while (s === v)
        begin
            @(negedge mclk_i);
            n++;
        end
    endtask
    initial
    begin
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = '0;
        hwdata = '0;
        void'($urandom(32'h9962862e));
        repeat (16) @(posedge mclk_i);
        reset_i <= 1'b0;
        // Reset value, then an unmapped word that ignores a random write.
        bus(1'b0, I2CRC_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        n = 32'h20 | ($urandom & 32'h1c);
        bus(1'b1, 8'(n), $urandom);
        bus(1'b0, 8'(n), 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, I2CRC_OFS_CTRL, 32'h30);
        repeat (20) @(posedge mclk_i);
        chk({scl_oe, sda_oe}, 2'b00);
        bus(1'b1, I2CRC_OFS_CTRL, 32'h84);
        bus(1'b0, I2CRC_OFS_CTRL, 32'h0);
        chk(rd, 32'h80);
        bus(1'b0, I2CRC_OFS_STAT, 32'h0);
        chk(rd[1], 1'b1);
        bus(1'b1, I2CRC_OFS_STAT, 32'h3);
        // One acked transmit byte per rate, with interrupt and stop.
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, I2CRC_OFS_RATE, {24'h0, rate_t[i]});
            bus(1'b1, I2CRC_OFS_MASK, 32'h1);
            bus(1'b1, I2CRC_OFS_CTRL, 32'hb0);
            hold_len(scl_oe, 1'b0);
            bus(1'b1, I2CRC_OFS_DATA, 32'h55);
            hold_len(scl_oe, 1'b1);
            hold_len(scl_oe, 1'b0);
            chk(n, mul_t[i] * div_t[i] / 2);
            hold_len(sda_oe, 1'b1);
            chk(n, hold_t[i]);
            do bus(1'b0, I2CRC_OFS_STAT, 32'h0); while (rd[0] !== 1'b1);
            chk(irq, 1'b0);
            bus(1'b1, I2CRC_OFS_CTRL, 32'hf0);
            @(negedge mclk_i);
            chk(irq, 1'b1);
            bus(1'b0, I2CRC_OFS_INFO, 32'h0);
            chk(rd[2:1], 2'b01);
            if (i == 0)
            begin
                bus(1'b1, I2CRC_OFS_CTRL, 32'hf4);
                bus(1'b0, I2CRC_OFS_STAT, 32'h0);
                chk(rd[1], 1'b0);
            end
            bus(1'b1, I2CRC_OFS_STAT, 32'h1);
            @(negedge mclk_i);
            chk(irq, 1'b0);
            bus(1'b1, I2CRC_OFS_CTRL, 32'h80);
            do bus(1'b0, I2CRC_OFS_INFO, 32'h0); while (rd[0] !== 1'b0);
            chk({rd[1], scl_oe, sda_oe}, 3'b000);
        end
        test_done();
    end
endmodule // i2c_rate_and_control_tb
`default_nettype wire
